// ===== hw/reset_pkg.sv
// Constants, types and helpers for the reset source and brown-out block
package reset_pkg;

  // Special-function register addresses
  localparam logic [7:0] CAUSE_ADDR = 8'h97;
  localparam logic [7:0] BOOT_ADDR = 8'he7;

  // Cause register bit positions
  localparam int SOFT_FLAG_BIT = 7;
  localparam int PIN_FLAG_BIT = 6;
  localparam int SEL_BO_FLAG_BIT = 2;
  localparam int FIX_BO_FLAG_BIT = 1;
  localparam int WDT_FLAG_BIT = 0;

  // Boot control register bit positions
  localparam int BOOT_SEL_BIT = 6;
  localparam int SOFT_TRIG_BIT = 5;

  // Values after power-on reset
  localparam logic [7:0] CAUSE_RESET = 8'h00;
  localparam logic BOOT_SEL_RESET = 1'b0;
  localparam logic POWER_ON_FLAG_RESET = 1'b1;

  // Pin must stay high this many clock periods to count as a reset
  localparam logic [4:0] PIN_RESET_CYCLES = 5'h18;
  // Least length of the system reset pulse in clock cycles
  localparam logic [2:0] SYS_RESET_CYCLES = 3'h4;

  // Detector thresholds in millivolts
  localparam logic [12:0] FIXED_LEVEL_MV = 13'h06a4;
  localparam logic [12:0] LEVEL_00_MV = 13'h07d0;
  localparam logic [12:0] LEVEL_01_MV = 13'h0960;
  localparam logic [12:0] LEVEL_10_MV = 13'h0e74;
  localparam logic [12:0] LEVEL_11_MV = 13'h1068;

  // Reset sequencer states, one-hot
  typedef enum logic [1:0] {
    seq_idle = 2'b01,
    seq_hold = 2'b10
  } seq_state_e;

  // Sticky flag: hardware set wins over a software clear
  function automatic logic sticky_next(input logic flag,
                                       input logic set,
                                       input logic clr);
    sticky_next = set | (flag & ~clr);
  endfunction : sticky_next

  // Selectable detector threshold for a level code
  function automatic logic [12:0] level_mv(input logic [1:0] code);
    case (code)
      2'h0: level_mv = LEVEL_00_MV;
      2'h1: level_mv = LEVEL_01_MV;
      2'h2: level_mv = LEVEL_10_MV;
      default: level_mv = LEVEL_11_MV;
    endcase
  endfunction : level_mv

endpackage : reset_pkg

// ===== hw/detector_event.sv
// Rising-edge event detector for one gated detector level
`timescale 1ns/1ps
module detector_event (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire logic level_in,
  output logic event_out
);

  logic prev_r;
  logic prev_nxt;

  // Disabled detector reads as quiet level
  always_comb begin
    prev_nxt = enable_in & level_in;
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  // One pulse when the gated level rises
  assign event_out = prev_nxt & ~prev_r;

endmodule : detector_event

// ===== hw/reset_source_brownout_logic.sv
// Reset source collection, cause flags and brown-out routing
// Operation
// RL1: Pin reset sets pin cause flag; write one clears, zero ignored.
// RL2: Writing one to soft trigger issues a full system reset.
// RL3: Soft trigger bit returns to zero by itself after being written.
// RL4: After soft reset, boot select one boots programming region, else application.
// RL5: Soft reset sets soft cause flag; write one clears, zero ignored.
// RL6: Fixed detector event sets fixed brown-out flag; only write one clears.
// RL7: Selectable detector event sets its flag; write one clears, zero ignored.
// RL8: Level code picks threshold: 2.0V, 2.4V, 3.7V, 4.2V.
// RL9: Fixed flag with both enables raises system flag interrupt.
// RL10: Selectable flag interrupts likewise and wakes power-down with keep-alive.
// RL11: Fixed brown-out reset enable turns fixed events into system resets.
// RL12: Selectable reset enable resets system, in power-down with keep-alive.
// RL13: Selectable detector disabled gives no flag, interrupt or reset.
// RL14: Watchdog overflow sets its flag, resets system when enabled.
// RL15: Watchdog flag set only by overflow; write one clears, zero ignored.
// RL16: Fetch beyond valid program memory forces a system reset.
// RL17: Nonzero clock divider select slows processor clock; zero keeps speed.
// RL18: Power-on flag set at power-up, untouched by warm resets.
// RL19: Outside party holds reset pin high at least 24 clocks.
// RL20: All requests merge into one system reset; cause flags survive it.
`timescale 1ns/1ps
module reset_source_brownout_logic
  import reset_pkg::*;
#(
  parameter logic [15:0] PROG_LIMIT = 16'h3fff
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic reset_pin_in,
  input wire logic fixed_brownout_detector_in,
  input wire logic selectable_brownout_detector_in,
  input wire logic selectable_detector_enable_in,
  input wire logic [1:0] brownout_level_select_in,
  input wire logic fixed_brownout_reset_enable_in,
  input wire logic selectable_brownout_reset_enable_in,
  input wire logic brownout_powerdown_keepalive_in,
  input wire logic system_flag_irq_enable_in,
  input wire logic fixed_brownout_irq_enable_in,
  input wire logic selectable_brownout_irq_enable_in,
  input wire logic power_down_in,
  input wire logic watchdog_overflow_in,
  input wire logic watchdog_reset_enable_in,
  input wire logic fetch_valid_in,
  input wire logic [15:0] fetch_addr_in,
  input wire logic [2:0] clock_divider_select_in,
  input wire logic boot_option_isp_in,
  input wire logic power_on_flag_clear_in,
  output logic sys_reset_out,
  output logic boot_from_isp_out,
  output logic system_flag_irq_out,
  output logic powerdown_wake_out,
  output logic [12:0] selectable_threshold_mv_out,
  output logic selectable_detector_on_out,
  output logic cpu_clk_en_out,
  output logic power_on_flag_out
);

  // Register strobes
  logic wr_cause;
  logic wr_boot;
  assign wr_cause = sfr_wr_in & (sfr_addr_in == CAUSE_ADDR);
  assign wr_boot = sfr_wr_in & (sfr_addr_in == BOOT_ADDR);

  // Detector gating: fixed one sleeps in power-down, selectable needs
  // its enable and, in power-down, the keep-alive bit
  logic fix_gate;
  logic sel_gate;
  logic fix_event;
  logic sel_event;
  assign fix_gate = ~power_down_in;
  assign sel_gate = selectable_detector_enable_in &
                    (~power_down_in | brownout_powerdown_keepalive_in); // RL13

  detector_event u_fix_event (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .enable_in(fix_gate),
    .level_in(fixed_brownout_detector_in),
    .event_out(fix_event)
  );

  detector_event u_sel_event (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .enable_in(sel_gate),
    .level_in(selectable_brownout_detector_in),
    .event_out(sel_event)
  );

  // External pin qualification counter
  logic [4:0] pin_cnt_r;
  logic [4:0] pin_cnt_nxt;
  logic pin_event;
  logic pin_active;
  always_comb begin
    pin_cnt_nxt = pin_cnt_r;
    if (!reset_pin_in) begin
      pin_cnt_nxt = 5'h00;
    end else if (pin_cnt_r != PIN_RESET_CYCLES) begin
      pin_cnt_nxt = 5'(pin_cnt_r + 5'h01);
    end
  end
  // Short glitches on the pin never reach the reset tree
  assign pin_event = reset_pin_in &
                     (pin_cnt_r == 5'(PIN_RESET_CYCLES - 5'h01)); // RL19
  assign pin_active = reset_pin_in & (pin_cnt_r == PIN_RESET_CYCLES);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_cnt_r <= 5'h00;
    end else begin
      pin_cnt_r <= pin_cnt_nxt;
    end
  end

  // Soft trigger and boot select
  logic soft_trig_r;
  logic soft_trig_nxt;
  logic boot_sel_r;
  logic boot_sel_nxt;
  always_comb begin
    // Trigger lives one cycle only, then hardware drops it
    soft_trig_nxt = wr_boot & sfr_wdata_in[SOFT_TRIG_BIT]; // RL2 RL3
    boot_sel_nxt = wr_boot ? sfr_wdata_in[BOOT_SEL_BIT] : boot_sel_r;
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      soft_trig_r <= 1'b0;
      boot_sel_r <= BOOT_SEL_RESET;
    end else begin
      soft_trig_r <= soft_trig_nxt;
      boot_sel_r <= boot_sel_nxt;
    end
  end

  // Individual reset requests
  logic fix_req;
  logic sel_req;
  logic wdt_req;
  logic illegal_req;
  logic any_req;
  assign fix_req = fix_event & fixed_brownout_reset_enable_in; // RL11
  assign sel_req = sel_event & selectable_brownout_reset_enable_in; // RL12
  assign wdt_req = watchdog_overflow_in & watchdog_reset_enable_in; // RL14
  assign illegal_req = fetch_valid_in & (fetch_addr_in > PROG_LIMIT); // RL16
  assign any_req = soft_trig_r | pin_event | pin_active | fix_req |
                   sel_req | wdt_req | illegal_req; // RL20

  // Cause flags, cleared only by power-on or a write of one
  logic [7:0] cause_r;
  logic [7:0] cause_nxt;
  logic [7:0] clr;
  always_comb begin
    clr = wr_cause ? sfr_wdata_in : 8'h00;
    cause_nxt = 8'h00;
    cause_nxt[SOFT_FLAG_BIT] = sticky_next(cause_r[SOFT_FLAG_BIT],
      soft_trig_r, clr[SOFT_FLAG_BIT]); // RL5
    cause_nxt[PIN_FLAG_BIT] = sticky_next(cause_r[PIN_FLAG_BIT],
      pin_event, clr[PIN_FLAG_BIT]); // RL1
    cause_nxt[SEL_BO_FLAG_BIT] = sticky_next(cause_r[SEL_BO_FLAG_BIT],
      sel_event, clr[SEL_BO_FLAG_BIT]); // RL7
    cause_nxt[FIX_BO_FLAG_BIT] = sticky_next(cause_r[FIX_BO_FLAG_BIT],
      fix_event, clr[FIX_BO_FLAG_BIT]); // RL6
    cause_nxt[WDT_FLAG_BIT] = sticky_next(cause_r[WDT_FLAG_BIT],
      watchdog_overflow_in, clr[WDT_FLAG_BIT]); // RL14 RL15
  end

  // Not touched by the system reset this block issues
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cause_r <= CAUSE_RESET;
    end else begin
      cause_r <= cause_nxt; // RL20
    end
  end

  // Power-on flag: only the power-on reset sets it
  logic pof_r;
  logic pof_nxt;
  always_comb begin
    pof_nxt = pof_r & ~power_on_flag_clear_in; // RL18
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pof_r <= POWER_ON_FLAG_RESET;
    end else begin
      pof_r <= pof_nxt;
    end
  end
  assign power_on_flag_out = pof_r;

  // Reset sequencer stretches any request to a clean pulse
  seq_state_e state_r;
  seq_state_e state_nxt;
  logic [2:0] hold_cnt_r;
  logic [2:0] hold_cnt_nxt;
  logic sys_reset_r;
  logic sys_reset_nxt;
  logic boot_isp_r;
  logic boot_isp_nxt;
  always_comb begin
    state_nxt = state_r;
    hold_cnt_nxt = hold_cnt_r;
    boot_isp_nxt = boot_isp_r;
    if (any_req) begin
      state_nxt = seq_hold;
      hold_cnt_nxt = 3'(SYS_RESET_CYCLES - 3'h1);
      // Soft reset boots where software asked; others use the option
      boot_isp_nxt = soft_trig_r ? boot_sel_r : boot_option_isp_in; // RL4
    end else begin
      case (state_r)
        seq_idle: begin
          state_nxt = seq_idle;
        end
        seq_hold: begin
          if (hold_cnt_r == 3'h0) begin
            state_nxt = seq_idle;
          end else begin
            hold_cnt_nxt = 3'(hold_cnt_r - 3'h1);
          end
        end
        default: begin
          state_nxt = seq_idle;
          hold_cnt_nxt = 3'h0;
        end
      endcase
    end
    sys_reset_nxt = (state_nxt == seq_hold); // RL20
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= seq_idle;
      hold_cnt_r <= 3'h0;
      sys_reset_r <= 1'b0;
      boot_isp_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      sys_reset_r <= sys_reset_nxt;
      boot_isp_r <= boot_isp_nxt;
    end
  end
  assign sys_reset_out = sys_reset_r;
  assign boot_from_isp_out = boot_isp_r;

  // Interrupt and wake routing from the brown-out flags
  logic fix_irq;
  logic sel_irq;
  assign fix_irq = cause_r[FIX_BO_FLAG_BIT] & fixed_brownout_irq_enable_in;
  assign sel_irq = cause_r[SEL_BO_FLAG_BIT] &
                   selectable_brownout_irq_enable_in;
  assign system_flag_irq_out = system_flag_irq_enable_in &
                               (fix_irq | sel_irq); // RL9 RL10
  assign powerdown_wake_out = power_down_in &
                              brownout_powerdown_keepalive_in &
                              system_flag_irq_enable_in & sel_irq; // RL10

  // Threshold code to the analog side, registered
  logic [12:0] thr_r;
  logic [12:0] thr_nxt;
  logic det_on_r;
  logic det_on_nxt;
  always_comb begin
    thr_nxt = level_mv(brownout_level_select_in); // RL8
    det_on_nxt = selectable_detector_enable_in; // RL13
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      thr_r <= LEVEL_00_MV;
      det_on_r <= 1'b0;
    end else begin
      thr_r <= thr_nxt;
      det_on_r <= det_on_nxt;
    end
  end
  assign selectable_threshold_mv_out = thr_r;
  assign selectable_detector_on_out = det_on_r;

  // Processor clock enable divider, divides by two to the select
  logic [6:0] div_cnt_r;
  logic [6:0] div_cnt_nxt;
  logic [6:0] div_mask;
  always_comb begin
    div_cnt_nxt = 7'(div_cnt_r + 7'h01);
    div_mask = 7'((8'h01 << clock_divider_select_in) - 8'h01);
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      div_cnt_r <= 7'h00;
    end else begin
      div_cnt_r <= div_cnt_nxt;
    end
  end
  // Zero select gives a mask of zero, so every cycle is enabled
  assign cpu_clk_en_out = ((div_cnt_r & div_mask) == 7'h00); // RL17

  // Read data, registered; unmapped addresses read zero
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  always_comb begin
    rdata_nxt = rdata_r;
    if (sfr_rd_in) begin
      if (sfr_addr_in == CAUSE_ADDR) begin
        rdata_nxt = cause_r;
      end else if (sfr_addr_in == BOOT_ADDR) begin
        rdata_nxt = {1'b0, boot_sel_r, soft_trig_r, 5'h00};
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign sfr_rdata_out = rdata_r;

  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  // A fresh write of one may legally re-arm the trigger
  trigger_self_clear_a: assert property ( // RL3
    (soft_trig_r && !(wr_boot && sfr_wdata_in[SOFT_TRIG_BIT]))
    |=> !soft_trig_r)
    else $error("soft trigger did not clear");
  soft_reset_pulse_a: assert property ( // RL2
    (wr_boot && sfr_wdata_in[SOFT_TRIG_BIT]) |=> ##1 sys_reset_out [*4])
    else $error("soft reset pulse too short");
  soft_flag_set_a: assert property ( // RL5
    soft_trig_r |=> cause_r[SOFT_FLAG_BIT])
    else $error("soft cause flag not set");
  pin_flag_set_a: assert property ( // RL1
    pin_event |=> cause_r[PIN_FLAG_BIT] && sys_reset_out)
    else $error("pin reset not recorded");
  wdt_zero_write_a: assert property ( // RL15
    (cause_r[WDT_FLAG_BIT] && wr_cause && !sfr_wdata_in[WDT_FLAG_BIT])
    |=> cause_r[WDT_FLAG_BIT])
    else $error("zero write cleared watchdog flag");
  wdt_reset_issue_a: assert property ( // RL14
    wdt_req |=> sys_reset_out && cause_r[WDT_FLAG_BIT])
    else $error("watchdog reset missing");
  illegal_fetch_a: assert property (illegal_req |=> sys_reset_out) // RL16
    else $error("illegal fetch did not reset");
  fixed_irq_route_a: assert property ( // RL9
    (cause_r[FIX_BO_FLAG_BIT] && system_flag_irq_enable_in &&
     fixed_brownout_irq_enable_in) |-> system_flag_irq_out)
    else $error("fixed brown-out interrupt missing");
  sel_disabled_quiet_a: assert property ( // RL13
    (!selectable_detector_enable_in && !cause_r[SEL_BO_FLAG_BIT] &&
     !wr_cause) |=> !cause_r[SEL_BO_FLAG_BIT])
    else $error("disabled detector set its flag");
  boot_region_a: assert property ( // RL4
    (soft_trig_r && boot_sel_r) |=> boot_from_isp_out)
    else $error("soft reset boot region wrong");
  pof_warm_keep_a: assert property ( // RL18
    (sys_reset_out && !power_on_flag_clear_in) |=> $stable(power_on_flag_out))
    else $error("warm reset changed power-on flag");
  clk_full_speed_a: assert property ( // RL17
    (clock_divider_select_in == 3'h0) |-> cpu_clk_en_out)
    else $error("clock slowed at zero select");

  soft_reset_c: cover property (soft_trig_r ##1 sys_reset_out);
  pin_reset_c: cover property (pin_event ##1 cause_r[PIN_FLAG_BIT]);
  sel_wake_c: cover property (powerdown_wake_out);
  fix_bo_reset_c: cover property (fix_req ##1 sys_reset_out);

endmodule : reset_source_brownout_logic

// ===== test/test_reset_source_brownout_logic.sv
// Self-checking bench for the reset source and brown-out block
`timescale 1ns/1ps
module test_reset_source_brownout_logic
  import reset_pkg::*;
;
  localparam int rl = SYS_RESET_CYCLES;
  logic mclk_in, rst_in, sfr_wr_in, sfr_rd_in, reset_pin_in;
  logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, rd;
  logic fixed_brownout_detector_in, selectable_brownout_detector_in;
  logic selectable_detector_enable_in, fixed_brownout_reset_enable_in;
  logic [1:0] brownout_level_select_in;
  logic selectable_brownout_reset_enable_in, brownout_powerdown_keepalive_in;
  logic system_flag_irq_enable_in, fixed_brownout_irq_enable_in;
  logic selectable_brownout_irq_enable_in, power_down_in;
  logic watchdog_overflow_in, watchdog_reset_enable_in, fetch_valid_in;
  logic [15:0] fetch_addr_in;
  logic [2:0] clock_divider_select_in;
  logic boot_option_isp_in, power_on_flag_clear_in, sys_reset_out;
  logic boot_from_isp_out, system_flag_irq_out, powerdown_wake_out;
  logic [12:0] selectable_threshold_mv_out;
  logic [12:0] mv_tbl [4] = '{13'h07d0, 13'h0960, 13'h0e74, 13'h1068};
  logic selectable_detector_on_out, cpu_clk_en_out, power_on_flag_out;
  int fails = 0;
  int cmp_count = 0;
  int k;

  reset_source_brownout_logic reset_source_brownout_logic_inst (
    .mclk_in, .rst_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in,
    .sfr_rdata_out, .reset_pin_in, .fixed_brownout_detector_in,
    .selectable_brownout_detector_in, .selectable_detector_enable_in,
    .brownout_level_select_in, .fixed_brownout_reset_enable_in,
    .selectable_brownout_reset_enable_in, .brownout_powerdown_keepalive_in,
    .system_flag_irq_enable_in, .fixed_brownout_irq_enable_in,
    .selectable_brownout_irq_enable_in, .power_down_in,
    .watchdog_overflow_in, .watchdog_reset_enable_in, .fetch_valid_in,
    .fetch_addr_in, .clock_divider_select_in, .boot_option_isp_in,
    .power_on_flag_clear_in, .sys_reset_out, .boot_from_isp_out,
    .system_flag_irq_out, .powerdown_wake_out, .selectable_threshold_mv_out,
    .selectable_detector_on_out, .cpu_clk_en_out, .power_on_flag_out
  );

  // 200 MHz system clock
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  task end_of_test();
    if (fails == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  // All tasks start and end just after a falling edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = 1'b1;
    @(negedge mclk_in);
    sfr_wr_in = 1'b0;
  endtask : wr

  // Read data is registered on the taking edge, so it is settled here
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr_in = a;
    sfr_rd_in = 1'b1;
    @(negedge mclk_in);
    sfr_rd_in = 1'b0;
    rd = sfr_rdata_out;
    check({8'h00, rd}, {8'h00, exp});
    // Idle edge, so a following read never re-raises the strobe at once
    @(negedge mclk_in);
    // Read data stands until the next read
    check({8'h00, sfr_rdata_out}, {8'h00, exp});
  endtask : rd_chk

  task automatic strobe(ref logic s);
    s = 1'b1;
    @(negedge mclk_in);
    s = 1'b0;
  endtask : strobe

  task pin_pulse(input int cycles);
    reset_pin_in = 1'b1;
    repeat (cycles) @(negedge mclk_in);
    reset_pin_in = 1'b0;
  endtask : pin_pulse

  // Latency window lo..hi and pulse length; lo = hi = 10 means no reset
  task wait_rst(input int lo, input int hi, input int len);
    int n;
    int h;
    n = 0;
    h = 0;
    while (n < 10 && sys_reset_out !== 1'b1) begin
      @(negedge mclk_in);
      n++;
    end
    while (sys_reset_out === 1'b1 && h < 40) begin
      @(negedge mclk_in);
      h++;
    end
    if (h >= 40) begin
      fails++;
      end_of_test();
    end
    check(16'(n >= lo && n <= hi), 16'h0001);
    check(16'(h), 16'(len));
  endtask : wait_rst

  // Hang guard well beyond the longest sequence
  initial begin
    repeat (20000) @(posedge mclk_in);
    fails++;
    end_of_test();
  end

  initial begin
    {rst_in, sfr_wr_in, sfr_rd_in, reset_pin_in} = 4'h8;
    {sfr_addr_in, sfr_wdata_in, fetch_addr_in} = 32'h0;
    {fixed_brownout_detector_in, selectable_brownout_detector_in} = 2'h0;
    {selectable_detector_enable_in, fixed_brownout_reset_enable_in} = 2'h0;
    {selectable_brownout_reset_enable_in, brownout_powerdown_keepalive_in} = 2'h0;
    {system_flag_irq_enable_in, fixed_brownout_irq_enable_in} = 2'h0;
    {selectable_brownout_irq_enable_in, power_down_in} = 2'h0;
    {watchdog_overflow_in, watchdog_reset_enable_in, fetch_valid_in} = 3'h0;
    {brownout_level_select_in, clock_divider_select_in} = 5'h00;
    {boot_option_isp_in, power_on_flag_clear_in} = 2'h0;
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in);
    rst_in = 1'b0;
    @(negedge mclk_in);
    check(16'(power_on_flag_out), 16'h0001);
    rd_chk(CAUSE_ADDR, 8'h00);
    rd_chk(8'h55, 8'h00);
    strobe(power_on_flag_clear_in);
    check(16'(power_on_flag_out), 16'h0000);
    // Soft reset into the programming region, then the application one
    wr(BOOT_ADDR, 8'h60);
    wait_rst(1, 1, rl);
    check(16'(boot_from_isp_out), 16'h0001);
    rd_chk(BOOT_ADDR, 8'h40);
    rd_chk(CAUSE_ADDR, 8'h80);
    check(16'(power_on_flag_out), 16'h0000);
    wr(CAUSE_ADDR, 8'h7f);
    rd_chk(CAUSE_ADDR, 8'h80);
    wr(CAUSE_ADDR, 8'h80);
    rd_chk(CAUSE_ADDR, 8'h00);
    wr(BOOT_ADDR, 8'h40);
    wait_rst(10, 10, 0);
    wr(BOOT_ADDR, 8'h20);
    wait_rst(1, 1, rl);
    check(16'(boot_from_isp_out), 16'h0000);
    wr(CAUSE_ADDR, 8'h80);
    // Pin one cycle short of qualifying, then exactly long enough
    pin_pulse(23);
    wait_rst(10, 10, 0);
    rd_chk(CAUSE_ADDR, 8'h00);
    pin_pulse(24);
    wait_rst(0, 0, rl);
    wr(CAUSE_ADDR, 8'hbf);
    rd_chk(CAUSE_ADDR, 8'h40);
    wr(CAUSE_ADDR, 8'h40);
    rd_chk(CAUSE_ADDR, 8'h00);
    // Watchdog overflow without and with reset enable
    strobe(watchdog_overflow_in);
    wait_rst(10, 10, 0);
    wr(CAUSE_ADDR, 8'h00);
    rd_chk(CAUSE_ADDR, 8'h01);
    watchdog_reset_enable_in = 1'b1;
    boot_option_isp_in = 1'b1;
    strobe(watchdog_overflow_in);
    wait_rst(0, 0, rl);
    check(16'(boot_from_isp_out), 16'h0001);
    boot_option_isp_in = 1'b0;
    wr(CAUSE_ADDR, 8'h01);
    rd_chk(CAUSE_ADDR, 8'h00);
    // Fetch at the last legal address, then one past it
    fetch_addr_in = 16'h3fff;
    strobe(fetch_valid_in);
    wait_rst(10, 10, 0);
    fetch_addr_in = 16'h4000;
    strobe(fetch_valid_in);
    wait_rst(0, 0, rl);
    rd_chk(CAUSE_ADDR, 8'h00);
    // Fixed detector: flag, interrupt gating, power-down, reset
    fixed_brownout_detector_in = 1'b1;
    wait_rst(10, 10, 0);
    rd_chk(CAUSE_ADDR, 8'h02);
    system_flag_irq_enable_in = 1'b1;
    fixed_brownout_irq_enable_in = 1'b1;
    @(negedge mclk_in);
    check(16'(system_flag_irq_out), 16'h0001);
    fixed_brownout_irq_enable_in = 1'b0;
    @(negedge mclk_in);
    check(16'(system_flag_irq_out), 16'h0000);
    fixed_brownout_irq_enable_in = 1'b1;
    wr(CAUSE_ADDR, 8'h02);
    rd_chk(CAUSE_ADDR, 8'h00);
    check(16'(system_flag_irq_out), 16'h0000);
    {fixed_brownout_detector_in, fixed_brownout_reset_enable_in} = 2'h1;
    power_down_in = 1'b1;
    @(negedge mclk_in);
    fixed_brownout_detector_in = 1'b1;
    wait_rst(10, 10, 0);
    rd_chk(CAUSE_ADDR, 8'h00);
    {fixed_brownout_detector_in, power_down_in} = 2'h0;
    @(negedge mclk_in);
    fixed_brownout_detector_in = 1'b1;
    wait_rst(1, 3, rl);
    rd_chk(CAUSE_ADDR, 8'h02);
    fixed_brownout_detector_in = 1'b0;
    wr(CAUSE_ADDR, 8'h02);
    // Level codes, then the selectable detector
    for (k = 0; k < 4; k++) begin
      brownout_level_select_in = 2'(k);
      @(negedge mclk_in);
      check(16'(selectable_threshold_mv_out), 16'(mv_tbl[k]));
    end
    selectable_brownout_reset_enable_in = 1'b1;
    selectable_brownout_detector_in = 1'b1;
    wait_rst(10, 10, 0);
    rd_chk(CAUSE_ADDR, 8'h00);
    check(16'(selectable_detector_on_out), 16'h0000);
    {selectable_brownout_detector_in, selectable_brownout_reset_enable_in} = 2'h0;
    selectable_detector_enable_in = 1'b1;
    selectable_brownout_irq_enable_in = 1'b1;
    @(negedge mclk_in);
    check(16'(selectable_detector_on_out), 16'h0001);
    selectable_brownout_detector_in = 1'b1;
    wait_rst(10, 10, 0);
    wr(CAUSE_ADDR, 8'h00);
    rd_chk(CAUSE_ADDR, 8'h04);
    check(16'(system_flag_irq_out), 16'h0001);
    power_down_in = 1'b1;
    @(negedge mclk_in);
    check(16'(powerdown_wake_out), 16'h0000);
    brownout_powerdown_keepalive_in = 1'b1;
    @(negedge mclk_in);
    check(16'(powerdown_wake_out), 16'h0001);
    selectable_brownout_detector_in = 1'b0;
    wr(CAUSE_ADDR, 8'h04);
    rd_chk(CAUSE_ADDR, 8'h00);
    selectable_brownout_reset_enable_in = 1'b1;
    selectable_brownout_detector_in = 1'b1;
    wait_rst(1, 3, rl);
    rd_chk(CAUSE_ADDR, 8'h04);
    {selectable_brownout_detector_in, brownout_powerdown_keepalive_in} = 2'h0;
    wr(CAUSE_ADDR, 8'h04);
    selectable_brownout_detector_in = 1'b1;
    wait_rst(10, 10, 0);
    rd_chk(CAUSE_ADDR, 8'h00);
    {selectable_brownout_detector_in, power_down_in} = 2'h0;
    // Any 16-cycle window holds 16 >> sel enables
    for (k = 0; k < 4; k++) begin
      clock_divider_select_in = 3'(k);
      repeat (4) @(negedge mclk_in);
      rd = 8'h00;
      repeat (16) begin
        @(negedge mclk_in);
        rd = rd + 8'(cpu_clk_en_out);
      end
      check({8'h00, rd}, 16'(16 >> k));
    end
    // A second power-on reset in mid-run
    rst_in = 1'b1;
    @(negedge mclk_in);
    // Divider counter sits at zero while reset is held
    check(16'(cpu_clk_en_out), 16'h0001);
    rst_in = 1'b0;
    @(negedge mclk_in);
    check(16'(power_on_flag_out), 16'h0001);
    check(16'(sys_reset_out), 16'h0000);
    end_of_test();
  end

endmodule : test_reset_source_brownout_logic
